// file: dv/mfi_core_model.sv
// core sequencer and service software stand-in for mfi_top
// assumes one clock, async active-high reset, bench pulses do_return_from_interrupt/do_ret
`timescale 1ns/1ps
`default_nettype none

module mfi_core_model (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic int_req,
	input wire logic ack_en,
	input wire logic [3:0] lag,
	input wire logic full,
	input wire logic do_return_from_interrupt,
	input wire logic do_ret,
	output mfi_pkg::mfi_core_t core
);
	logic [3:0] wait_cnt;
	logic ack_q;
	logic return_from_interrupt_q;
	logic ret_q;

	// slow answers come from lag; one ack per offer, never a nested call
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wait_cnt <= 4'h0;
			ack_q <= 1'b0;
			return_from_interrupt_q <= 1'b0;
			ret_q <= 1'b0;
		end else begin
			ack_q <= 1'b0;
			return_from_interrupt_q <= do_return_from_interrupt;
			ret_q <= do_ret;
			if (int_req && ack_en && !ack_q) begin
				if (wait_cnt >= lag) begin
					ack_q <= 1'b1;
					wait_cnt <= 4'h0;
				end else begin
					wait_cnt <= wait_cnt + 4'h1;
				end
			end
		end
	end

	assign core = {ack_q, return_from_interrupt_q, ret_q, full};
endmodule // mfi_core_model
`default_nettype wire

// file: dv/tb_multi_function_interrupt_logic.sv
// self-checking bench for mfi_top with a core model on the far side
// assumes 250 MHz clk_sys and the register map of mfi_cfg.svh
`timescale 1ns/1ps
`default_nettype none

module tb_multi_function_interrupt_logic;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	mfi_pkg::mfi_bus_t bus = '0;
	logic [15:0] rdata;
	logic ovf = 1'b0;
	logic [5:0] ucond = 6'h00;
	logic ee = 1'b0;
	logic lvs = 1'b0;
	logic [2:0] tpm = 3'h0;
	logic [2:0] tam = 3'h0;
	mfi_pkg::mfi_core_t core;
	logic int_req, stack_push, stack_pop, uart_pulse_n, wake_up, irq;
	logic [15:0] int_vector, stack_data, sd, vec;
	logic ack_en = 1'b0;
	logic full = 1'b0;
	logic do_return_from_interrupt = 1'b0;
	logic do_ret = 1'b0;
	logic w_hit, p_hit, q_hit, u_hit, r_hit;
	int failures = 0;
	int samples_checked = 0;

	always #2 clk_sys = ~clk_sys;

	mfi_top #(.NTM(3), .PCW(16)) mfi_top_inst (.clk_sys(clk_sys), .rst(rst),
		.ce(ce), .bus(bus), .rdata(rdata), .bus_timeout_ovf(ovf),
		.uart_cond(ucond), .eeprom_wr_end(ee), .low_supply_async(lvs),
		.tm_period_match(tpm), .tm_cmpa_match(tam), .core(core),
		.pc_in(16'h1234), .int_req(int_req), .int_vector(int_vector),
		.stack_push(stack_push), .stack_pop(stack_pop),
		.stack_data(stack_data), .uart_pulse_n(uart_pulse_n),
		.wake_up(wake_up), .irq(irq));

	mfi_core_model mfi_core_model_inst (.clk_sys(clk_sys), .rst(rst),
		.int_req(int_req), .ack_en(ack_en), .lag(4'h3), .full(full),
		.do_return_from_interrupt(do_return_from_interrupt), .do_ret(do_ret), .core(core));

	// ************************************************************
	// shared tasks; each but chk is entered in the time step of a rising edge, chk also at a falling edge or 1 ns after a rising one
	// ************************************************************
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task wr(input logic [3:0] a, input logic [15:0] d);
		bus <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys);
		bus <= '0;
		@(posedge clk_sys);
	endtask

	task rd(input logic [3:0] a, input logic [15:0] exp);
		bus <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge clk_sys);
		bus <= '0;
		#1 chk(rdata, exp);
		@(posedge clk_sys);
	endtask

	// pulses are caught at the falling edge, away from the launch edge
	task watch(input int n);
		{w_hit, p_hit, q_hit, u_hit, r_hit} = '0;
		repeat (n) begin
			@(negedge clk_sys);
			w_hit |= (wake_up === 1'b1);
			q_hit |= (stack_pop === 1'b1);
			u_hit |= (uart_pulse_n === 1'b0);
			if (stack_push === 1'b1) begin
				p_hit = 1'b1;
				sd = stack_data;
			end
			if (int_req === 1'b1) begin
				r_hit = 1'b1;
				vec = int_vector;
			end
		end
		@(posedge clk_sys);
	endtask

	task wrap_up;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	task t_reset;
		rd(4'h0, 16'h0000);
		rd(4'h7, 16'h0010);
		// read data stands one cycle only; outputs idle out of reset
		@(negedge clk_sys);
		chk(rdata, 16'h0000);
		chk(16'({int_req, stack_push, stack_pop, wake_up, irq}), 16'h0000);
		@(posedge clk_sys);
		wr(4'h9, 16'hffff);
		rd(4'h9, 16'h0000);
		@(negedge clk_sys);
		chk(16'(uart_pulse_n), 16'h0001);
		@(posedge clk_sys);
	endtask

	// clock enable low: writes and events are both lost
	task t_freeze;
		ce <= 1'b0;
		wr(4'h0, 16'h0001);
		ovf <= 1'b1;
		@(posedge clk_sys);
		ovf <= 1'b0;
		ce <= 1'b1;
		rd(4'h0, 16'h0000);
		rd(4'h1, 16'h0000);
	endtask

	task t_wake;
		wr(4'h0, 16'h0004);
		ovf <= 1'b1;
		@(posedge clk_sys);
		ovf <= 1'b0;
		watch(6);
		chk(16'(w_hit), 16'h0001);
		rd(4'h1, 16'h0001);
		// software presets the flag high before sleep: no wake expected
		wr(4'h1, 16'h0000);
		wr(4'h1, 16'h0001);
		wr(4'h0, 16'h0004);
		ovf <= 1'b1;
		@(posedge clk_sys);
		ovf <= 1'b0;
		watch(6);
		chk(16'(w_hit), 16'h0000);
		rd(4'h1, 16'h0001);
		rd(4'h5, 16'h0010);
		wr(4'h6, 16'h0010);
		@(negedge clk_sys);
		chk(16'(irq), 16'h0001);
		@(posedge clk_sys);
		wr(4'h5, 16'h0010);
		@(negedge clk_sys);
		chk(16'(irq), 16'h0000);
		@(posedge clk_sys);
		wr(4'h6, 16'h0000);
		wr(4'h0, 16'h0000);
		wr(4'h1, 16'h0000);
	endtask

	task t_service;
		wr(4'h2, 16'h03ff);
		wr(4'h4, 16'h000f);
		wr(4'h0, 16'h0003);
		ack_en <= 1'b1;
		ee <= 1'b1;
		@(posedge clk_sys);
		ee <= 1'b0;
		watch(14);
		ack_en <= 1'b0;
		chk(16'(r_hit), 16'h0001);
		chk(vec, 16'h0018);
		chk(16'(p_hit), 16'h0001);
		chk(sd, 16'h1234);
		rd(4'h3, 16'h0000);
		rd(4'h1, 16'h0002);
		rd(4'h0, 16'h0002);
		do_return_from_interrupt <= 1'b1;
		@(posedge clk_sys);
		do_return_from_interrupt <= 1'b0;
		watch(6);
		chk(16'(q_hit), 16'h0001);
		rd(4'h0, 16'h0003);
		wr(4'h0, 16'h0002);
		do_ret <= 1'b1;
		@(posedge clk_sys);
		do_ret <= 1'b0;
		watch(6);
		chk(16'(q_hit), 16'h0001);
		rd(4'h0, 16'h0002);
		wr(4'h1, 16'h0000);
	endtask

	task t_full;
		full <= 1'b1;
		wr(4'h0, 16'h0003);
		ee <= 1'b1;
		@(posedge clk_sys);
		ee <= 1'b0;
		watch(6);
		chk(16'(r_hit), 16'h0000);
		full <= 1'b0;
		watch(4);
		chk(16'(r_hit), 16'h0001);
		wr(4'h0, 16'h0002);
		wr(4'h3, 16'h0000);
		wr(4'h1, 16'h0000);
	endtask

	task t_uart;
		for (int i = 0; i < 6; i++) begin
			ucond <= 6'(1 << i);
			@(posedge clk_sys);
			watch(4);
			chk(16'(u_hit), 16'h0001);
			ucond <= 6'h00;
			@(posedge clk_sys);
		end
		rd(4'h3, 16'h0008);
		wr(4'h3, 16'h0000);
		// uart enable off: pulse still leaves, group stays clear
		wr(4'h0, 16'h0000);
		ucond <= 6'h01;
		@(posedge clk_sys);
		ucond <= 6'h00;
		watch(3);
		chk(16'(u_hit), 16'h0001);
		rd(4'h3, 16'h0000);
	endtask

	task t_timers;
		tpm <= 3'h4;
		tam <= 3'h1;
		@(posedge clk_sys);
		tpm <= 3'h0;
		tam <= 3'h0;
		@(posedge clk_sys);
		rd(4'h1, 16'h0090);
		rd(4'h3, 16'h0003);
		rd(4'h7, 16'h0010);
		wr(4'h3, 16'h0006);
		rd(4'h7, 16'h0014);
		lvs <= 1'b1;
		repeat (6) @(posedge clk_sys);
		rd(4'h1, 16'h0094);
	endtask

	initial begin
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		t_reset();
		t_freeze();
		t_wake();
		t_service();
		t_full();
		t_uart();
		t_timers();
		wrap_up();
	end

	// whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk_sys);
		failures++;
		wrap_up();
	end
endmodule // tb_multi_function_interrupt_logic
`default_nettype wire

// file: rtl/mfi_cfg.svh
// constants of the multi-function interrupt logic: offsets, fields, resets
// assumes it is included by bare name from the package and the top module
`ifndef MFI_CFG_SVH
`define MFI_CFG_SVH

// ************************************************************
// register port
// ************************************************************
`define MFI_AW 4
`define MFI_DW 16
`define MFI_OFS_CTRL 4'h0
`define MFI_OFS_SUB_FLAG 4'h1
`define MFI_OFS_SUB_EN 4'h2
`define MFI_OFS_GRP_FLAG 4'h3
`define MFI_OFS_GRP_EN 4'h4
`define MFI_OFS_STAT 4'h5
`define MFI_OFS_MASK 4'h6
`define MFI_OFS_VEC 4'h7

// ************************************************************
// control fields and reset values
// ************************************************************
`define MFI_CTRL_GIE 0
`define MFI_CTRL_UIE 1
`define MFI_CTRL_SLEEP 2
`define MFI_RST_BIT 1'b0
`define MFI_RST_WORD 16'h0000

// ************************************************************
// sub-source layout: fixed three, then period/compare-a per timer
// ************************************************************
`define MFI_SUB_BTO 0
`define MFI_SUB_EE 1
`define MFI_SUB_LV 2
`define MFI_SUB_TM 3
`define MFI_NTM_DEF 3

// ************************************************************
// groups
// ************************************************************
`define MFI_NGRP 4
`define MFI_GW 2
`define MFI_GRP_TMP 2'h0
`define MFI_GRP_TMA 2'h1
`define MFI_GRP_SUP 2'h2
`define MFI_GRP_COM 2'h3
`define MFI_UART_NCOND 6
`define MFI_VEC_BASE 16'h0010
`define MFI_VEC_STEP 16'h0004

`endif

// file: rtl/mfi_pkg.sv
// types shared by the multi-function interrupt logic and its bench
// assumes mfi_cfg.svh is on the include path
`include "mfi_cfg.svh"

package mfi_pkg;

	// one cycle register access from software
	typedef struct packed {
		logic we;
		logic re;
		logic [`MFI_AW-1:0] addr;
		logic [`MFI_DW-1:0] wdata;
	} mfi_bus_t;

	// strobes from the core sequencer, each one cycle, plus the stack_full level
	typedef struct packed {
		logic ack;
		logic return_from_interrupt;
		logic ret_plain;
		logic stack_full;
	} mfi_core_t;

endpackage

// file: rtl/mfi_top.sv
// multi-function interrupt logic: sub-source flags, groups, vectoring, wake
// assumes timer, eeprom, bus time-out and uart strobes share clk_sys;
// the supply monitor level is asynchronous and is synchronised here
//
// Summary of operation
// - bus time-out overflow sets its flag
// - call needs global, own, group enables, stack room
// - service clears global enable and group flag only
// - six uart conditions raise uart request, uart-enabled
// - uart signals with an active-low pulse
// - servicing never clears uart status flags
// - eeprom write end sets its flag
// - low supply sets its flag
// - each timer: period and compare-a flags
// - in sleep any sub-source flag rise wakes, enables ignored; uart wakes only when uart-enabled
// - flags hold until serviced or cleared
// - entry pushes only the program counter
// - interrupt return sets global enable
// - plain return leaves global enable unchanged
// - any included sub-source rise sets group flag
`timescale 1ns/1ps
`default_nettype none
`include "mfi_cfg.svh"

module mfi_top #(
	parameter int NTM = `MFI_NTM_DEF,
	parameter int PCW = 16
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire mfi_pkg::mfi_bus_t bus,
	output logic [`MFI_DW-1:0] rdata,
	input wire logic bus_timeout_ovf,
	input wire logic [`MFI_UART_NCOND-1:0] uart_cond,
	input wire logic eeprom_wr_end,
	input wire logic low_supply_async,
	input wire logic [NTM-1:0] tm_period_match,
	input wire logic [NTM-1:0] tm_cmpa_match,
	input wire mfi_pkg::mfi_core_t core,
	input wire logic [PCW-1:0] pc_in,
	output logic int_req,
	output logic [`MFI_DW-1:0] int_vector,
	output logic stack_push,
	output logic stack_pop,
	output logic [PCW-1:0] stack_data,
	output logic uart_pulse_n,
	output logic wake_up,
	output logic irq
);

	localparam int NSUB = `MFI_SUB_TM + 2 * NTM;
	localparam int NST = `MFI_NGRP + 1;

	// ************************************************************
	// group membership
	// ************************************************************
	function automatic logic [`MFI_GW-1:0] grp_of(input int k);
		logic [`MFI_GW-1:0] g;
		g = `MFI_GRP_TMP;
		if (k == `MFI_SUB_BTO)
			g = `MFI_GRP_COM;
		else if (k < `MFI_SUB_TM)
			g = `MFI_GRP_SUP;
		else if (((k - `MFI_SUB_TM) % 2) != 0)
			g = `MFI_GRP_TMA;
		return g;
	endfunction

	// ************************************************************
	// state
	// ************************************************************
	logic [NSUB-1:0] sub_flag;
	logic [NSUB-1:0] sub_en;
	logic [`MFI_NGRP-1:0] grp_flag;
	logic [`MFI_NGRP-1:0] grp_en;
	logic [NST-1:0] stat;
	logic [NST-1:0] mask;
	logic gie;
	logic uart_int_enable;
	logic sleep;
	logic lv_s1;
	logic lv_s2;
	logic lv_s3;
	logic [`MFI_UART_NCOND-1:0] uart_cond_q;
	logic [`MFI_GW-1:0] sel_q;

	// ************************************************************
	// decode
	// ************************************************************
	wire wr_ctrl = ce & bus.we & (bus.addr == `MFI_OFS_CTRL);
	wire wr_sub = ce & bus.we & (bus.addr == `MFI_OFS_SUB_FLAG);
	wire wr_sen = ce & bus.we & (bus.addr == `MFI_OFS_SUB_EN);
	wire wr_grp = ce & bus.we & (bus.addr == `MFI_OFS_GRP_FLAG);
	wire wr_gen = ce & bus.we & (bus.addr == `MFI_OFS_GRP_EN);
	wire wr_stat = ce & bus.we & (bus.addr == `MFI_OFS_STAT);
	wire wr_mask = ce & bus.we & (bus.addr == `MFI_OFS_MASK);

	// ************************************************************
	// sub-source events
	// ************************************************************
	logic [NSUB-1:0] sub_set;
	wire lv_rise = lv_s2 & ~lv_s3;
	assign sub_set[`MFI_SUB_BTO] = bus_timeout_ovf;
	assign sub_set[`MFI_SUB_EE] = eeprom_wr_end;
	assign sub_set[`MFI_SUB_LV] = lv_rise;

	genvar gi;
	generate
		for (gi = 0; gi < NTM; gi++) begin : g_tm
			assign sub_set[`MFI_SUB_TM + 2 * gi] = tm_period_match[gi];
			assign sub_set[`MFI_SUB_TM + 2 * gi + 1] = tm_cmpa_match[gi];
		end
	endgenerate

	// uart condition edges; status flags live inside the uart
	wire uart_any = |(uart_cond & ~uart_cond_q);
	wire uart_evt = ~uart_pulse_n & uart_int_enable;

	// ************************************************************
	// group events and vectoring
	// ************************************************************
	logic [`MFI_NGRP-1:0] grp_set;
	wire [NSUB-1:0] sub_arm = sub_set & sub_en;
	generate
		for (gi = 0; gi < `MFI_NGRP; gi++) begin : g_grp
			logic [NSUB-1:0] memb;
			for (genvar k = 0; k < NSUB; k++) begin : g_m
				assign memb[k] = (grp_of(k) == `MFI_GW'(gi));
			end
			if (gi == `MFI_GRP_COM) begin : g_com
				assign grp_set[gi] = |(sub_arm & memb) | uart_evt;
			end else begin : g_oth
				assign grp_set[gi] = |(sub_arm & memb);
			end
		end
	endgenerate

	wire [`MFI_NGRP-1:0] pend = grp_flag & grp_en;
	logic [`MFI_GW-1:0] first_grp;
	always_comb begin
		first_grp = '0;
		for (int g = `MFI_NGRP - 1; g >= 0; g--) begin
			if (pend[g])
				first_grp = g[`MFI_GW-1:0];
		end
	end

	wire svc = ce & core.ack & int_req;
	// stack room is the core's; hardware only refuses to call when full
	wire next_req = gie & ~core.stack_full & (|pend) & ~svc;
	wire [`MFI_NGRP-1:0] svc_clr = svc ? (`MFI_NGRP'(1) << sel_q) : '0;

	wire sub_rise = |(sub_set & ~sub_flag);
	wire grp_rise = |(grp_set & ~grp_flag);
	wire wake_evt = sleep & (sub_rise | grp_rise);
	wire [NST-1:0] st_set = {wake_evt, grp_set};

	// ************************************************************
	// read mux
	// ************************************************************
	logic [`MFI_DW-1:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		case (bus.addr)
			`MFI_OFS_CTRL: rd_mux = `MFI_DW'({sleep, uart_int_enable, gie});
			`MFI_OFS_SUB_FLAG: rd_mux = `MFI_DW'(sub_flag);
			`MFI_OFS_SUB_EN: rd_mux = `MFI_DW'(sub_en);
			`MFI_OFS_GRP_FLAG: rd_mux = `MFI_DW'(grp_flag);
			`MFI_OFS_GRP_EN: rd_mux = `MFI_DW'(grp_en);
			`MFI_OFS_STAT: rd_mux = `MFI_DW'(stat);
			`MFI_OFS_MASK: rd_mux = `MFI_DW'(mask);
			`MFI_OFS_VEC: rd_mux = int_vector;
			default: rd_mux = '0;
		endcase
	end

	assign irq = |(stat & mask);

	// ************************************************************
	// flags: set wins over any clear in the same cycle
	// ************************************************************
	generate
		for (gi = 0; gi < NSUB; gi++) begin : g_sub
			// servicing never touches these; only software clears
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst)
					sub_flag[gi] <= `MFI_RST_BIT;
				else if (ce)
					sub_flag[gi] <= (wr_sub ? bus.wdata[gi] : sub_flag[gi])
						| sub_set[gi];
			end
		end
	endgenerate

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			grp_flag <= '0;
		else if (ce)
			grp_flag <= ((wr_grp ? bus.wdata[`MFI_NGRP-1:0] : grp_flag)
				& ~svc_clr) | grp_set;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sub_en <= '0;
			grp_en <= '0;
			mask <= '0;
		end else if (ce) begin
			if (wr_sen)
				sub_en <= bus.wdata[NSUB-1:0];
			if (wr_gen)
				grp_en <= bus.wdata[`MFI_NGRP-1:0];
			if (wr_mask)
				mask <= bus.wdata[NST-1:0];
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			stat <= '0;
		else if (ce)
			stat <= (wr_stat ? stat & ~bus.wdata[NST-1:0] : stat) | st_set;
	end

	// ************************************************************
	// control: service beats interrupt return beats software
	// ************************************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			gie <= `MFI_RST_BIT;
			uart_int_enable <= `MFI_RST_BIT;
			sleep <= `MFI_RST_BIT;
		end else if (ce) begin
			if (svc)
				gie <= 1'b0;
			else if (core.return_from_interrupt)
				gie <= 1'b1;
			else if (wr_ctrl)
				gie <= bus.wdata[`MFI_CTRL_GIE];
			// plain return has no say over the global enable
			if (wr_ctrl)
				uart_int_enable <= bus.wdata[`MFI_CTRL_UIE];
			// wake leaves the low-power mode, even against a write
			if (wake_evt)
				sleep <= 1'b0;
			else if (wr_ctrl)
				sleep <= bus.wdata[`MFI_CTRL_SLEEP];
		end
	end

	// ************************************************************
	// core handshake and stack
	// ************************************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			int_req <= 1'b0;
			sel_q <= '0;
			int_vector <= `MFI_VEC_BASE;
			stack_push <= 1'b0;
			stack_pop <= 1'b0;
			stack_data <= '0;
		end else if (ce) begin
			int_req <= next_req;
			sel_q <= first_grp;
			int_vector <= `MFI_VEC_BASE + `MFI_VEC_STEP * `MFI_DW'(first_grp);
			stack_push <= svc;
			stack_pop <= core.return_from_interrupt | core.ret_plain;
			if (svc)
				stack_data <= pc_in;
		end
	end

	// ************************************************************
	// synchroniser, uart pulse, wake, read data
	// ************************************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lv_s1 <= 1'b0;
			lv_s2 <= 1'b0;
			lv_s3 <= 1'b0;
			uart_cond_q <= '0;
			uart_pulse_n <= 1'b1;
			wake_up <= 1'b0;
			rdata <= `MFI_RST_WORD;
		end else if (ce) begin
			lv_s1 <= low_supply_async;
			lv_s2 <= lv_s1;
			lv_s3 <= lv_s2;
			uart_cond_q <= uart_cond;
			// only a pulse leaves here; uart status stays untouched
			uart_pulse_n <= ~uart_any;
			wake_up <= wake_evt;
			rdata <= bus.re ? rd_mux : `MFI_RST_WORD;
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	a_bto_sets_flag: assert property (@(posedge clk_sys) disable iff (rst)
		ce && bus_timeout_ovf |=> sub_flag[`MFI_SUB_BTO])
		else $error("bus time-out did not set its flag");

	a_req_needs_gie: assert property (@(posedge clk_sys) disable iff (rst)
		ce && (!gie || core.stack_full) |=> !int_req)
		else $error("request raised without enable or stack room");

	a_svc_clears: assert property (@(posedge clk_sys) disable iff (rst)
		svc && !grp_set[sel_q] |=> !gie && !grp_flag[$past(sel_q)])
		else $error("service left enable or group flag set");

	a_svc_keeps_sub: assert property (@(posedge clk_sys) disable iff (rst)
		ce && !wr_sub |=> (sub_flag & $past(sub_flag)) == $past(sub_flag))
		else $error("sub-source flag dropped without software");

	a_uart_pulse_low: assert property (@(posedge clk_sys) disable iff (rst)
		ce && uart_any ##1 ce && !uart_any |=> uart_pulse_n)
		else $error("uart pulse longer than its event");

	a_uart_to_grp: assert property (@(posedge clk_sys) disable iff (rst)
		ce && !uart_pulse_n && uart_int_enable |=> grp_flag[`MFI_GRP_COM])
		else $error("uart event did not reach its group");

	a_ee_sets_flag: assert property (@(posedge clk_sys) disable iff (rst)
		ce && eeprom_wr_end |=> sub_flag[`MFI_SUB_EE])
		else $error("eeprom end did not set its flag");

	a_lv_sets_flag: assert property (@(posedge clk_sys) disable iff (rst)
		ce && $rose(lv_s2) |=> sub_flag[`MFI_SUB_LV])
		else $error("low supply did not set its flag");

	a_tm_sets_flag: assert property (@(posedge clk_sys) disable iff (rst)
		ce && tm_cmpa_match[0] |=> sub_flag[`MFI_SUB_TM + 1])
		else $error("timer compare did not set its flag");

	a_wake_on_rise: assert property (@(posedge clk_sys) disable iff (rst)
		ce && sleep && sub_rise |=> wake_up && !sleep)
		else $error("flag rise in sleep did not wake");

	a_push_pc: assert property (@(posedge clk_sys) disable iff (rst)
		svc |=> stack_push && stack_data == $past(pc_in))
		else $error("entry did not push the program counter");

	a_return_from_interrupt_sets_gie: assert property (@(posedge clk_sys) disable iff (rst)
		ce && core.return_from_interrupt && !svc |=> gie && stack_pop)
		else $error("interrupt return did not set global enable");

	a_ret_keeps_gie: assert property (@(posedge clk_sys) disable iff (rst)
		ce && core.ret_plain && !core.return_from_interrupt && !svc && !wr_ctrl
		|=> gie == $past(gie))
		else $error("plain return changed global enable");

	a_grp_from_sub: assert property (@(posedge clk_sys) disable iff (rst)
		ce && sub_set[`MFI_SUB_EE] && sub_en[`MFI_SUB_EE]
		|=> grp_flag[`MFI_GRP_SUP])
		else $error("sub-source did not set its group flag");

	a_prio_lowest: assert property (@(posedge clk_sys) disable iff (rst)
		ce && pend[0] |=> sel_q == '0)
		else $error("lowest pending group not selected");

endmodule // mfi_top
`default_nettype wire
